// [rtl/static_mem_pkg.sv]
// shared constants, types and helpers for the static memory cycle sequencer
// Summary of operation
// - Address valid one clock before select asserts
// - Address held one clock after select deasserts
// - Byte read beats last wait count plus one
// - First halfword address change after wait plus one
// - Final beat holds select wait plus two
// - Byte-bus read strobe spans four beats
// - Halfword-bus read strobe spans both beats
// - Write strobe rises 2-4 clocks after release
// - Select rises 3-5 clocks after release
// - Idle gap between different selects
// - Idle gap on read/write direction change
// - Idle gap before synchronous memory access
// - Address and data lines shared with SDRAM
// - Narrow devices get split sequential accesses
package static_mem_pkg;

  localparam int NUM_CS = 6;
  localparam int CS_W   = 3;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int WST_W  = 5;
  localparam int IDC_W  = 4;
  localparam int CNT_W  = 8;

  // clock period in ns, and the fixed phases in bus clock periods
  localparam int                CLK_PERIOD_NS     = 10;
  localparam int                ADDR_SETUP_CYCLES = 1;
  localparam int                ADDR_HOLD_CYCLES  = 1;
  localparam logic [CNT_W-1:0]  BEAT_PHASE_EXTRA  = 8'h01;
  localparam logic [CNT_W-1:0]  LAST_PHASE_EXTRA  = 8'h02;
  localparam logic [3:0]        LANES_IDLE        = 4'hf;

  typedef enum logic [1:0] {
    BUS_8  = 2'h0,
    BUS_16 = 2'h1,
    BUS_32 = 2'h2
  } bus_width_type;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_SETUP   = 8'h02,
    ST_READ    = 8'h04,
    ST_WRITE   = 8'h08,
    ST_WAITING = 8'h10,
    ST_WREND   = 8'h20,
    ST_HOLD    = 8'h40,
    ST_SDGAP   = 8'h80
  } seq_state_type;

  // accesses needed to move one 32-bit word
  function automatic logic [2:0] beat_count(input bus_width_type w);
    unique case (w)
      BUS_8:   beat_count = 3'h4;
      BUS_16:  beat_count = 3'h2;
      default: beat_count = 3'h1;
    endcase
  endfunction

  // address step between beats, in bytes
  function automatic logic [2:0] byte_step(input bus_width_type w);
    unique case (w)
      BUS_8:   byte_step = 3'h1;
      BUS_16:  byte_step = 3'h2;
      default: byte_step = 3'h4;
    endcase
  endfunction

  // byte lanes that a device of this width uses
  function automatic logic [3:0] lane_enable(input bus_width_type w);
    unique case (w)
      BUS_8:   lane_enable = 4'h1;
      BUS_16:  lane_enable = 4'h3;
      default: lane_enable = 4'hf;
    endcase
  endfunction

endpackage

// [rtl/timing_if.sv]
// carrier between the sequencer and its phase timer and turnaround guard
`timescale 1ns/10ps
interface timing_if;
  import static_mem_pkg::*;

  logic                tmrLoad;
  logic [CNT_W-1:0]    tmrValue;
  logic                tmrDone;
  logic                accStart;
  logic                accWrite;
  logic [CS_W-1:0]     accCs;
  logic [IDC_W-1:0]    accIdle;
  logic                nxtWrite;
  logic [CS_W-1:0]     nxtCs;
  logic                nxtSync;
  logic                csHigh;
  logic                gapOk;

  modport ctrl (output tmrLoad, tmrValue, accStart, accWrite, accCs, accIdle,
                output nxtWrite, nxtCs, nxtSync, csHigh, input tmrDone, gapOk);
  modport timer (input tmrLoad, tmrValue, output tmrDone);
  modport guard (input accStart, accWrite, accCs, accIdle, nxtWrite, nxtCs, nxtSync,
                 input csHigh, output gapOk);
endinterface

// [rtl/phase_timer.sv]
// down counter that times one address phase
`timescale 1ns/10ps
module phase_timer (
  // clock and control
  input wire logic   clk,
  input wire logic   reset,
  input wire logic   clkEnable,
  // phase control
  timing_if.timer    tt
);
  import static_mem_pkg::*;

  logic [CNT_W-1:0]  cntReg;
  logic [CNT_W-1:0]  cntNext;

  // a load of n makes done show in the n-th cycle after the load
  assign cntNext = tt.tmrLoad ? CNT_W'(tt.tmrValue - 8'h01) :
                   (cntReg != 8'h00) ? CNT_W'(cntReg - 8'h01) : cntReg;
  assign tt.tmrDone = (cntReg == 8'h00);

  // counter register
  always_ff @(posedge clk) begin
    if (reset) begin
      cntReg <= 8'h00;
    end else if (clkEnable) begin
      cntReg <= cntNext;
    end
  end

endmodule

// [rtl/turnaround_guard.sv]
// remembers the last static access and holds off the next select
`timescale 1ns/10ps
module turnaround_guard (
  // clock and control
  input wire logic   clk,
  input wire logic   reset,
  input wire logic   clkEnable,
  // access history and gap answer
  timing_if.guard    tg
);
  import static_mem_pkg::*;

  logic                lastValidReg;
  logic                lastWriteReg;
  logic [CS_W-1:0]     lastCsReg;
  logic [IDC_W-1:0]    lastIdleReg;
  logic [IDC_W:0]      highRunReg;
  logic                needGap;

  assign needGap  = lastValidReg && (tg.nxtSync || (tg.nxtWrite != lastWriteReg) ||
                    (tg.nxtCs != lastCsReg));
  // run counts select-high cycles before this one; one wider so it never wraps
  assign tg.gapOk = !needGap || (highRunReg >= {1'b0, lastIdleReg});

  // history of the access just started
  always_ff @(posedge clk) begin
    if (reset) begin
      lastValidReg <= 1'b0;
      lastWriteReg <= 1'b0;
      lastCsReg    <= '0;
      lastIdleReg  <= '0;
    end else if (clkEnable && tg.accStart) begin
      lastValidReg <= 1'b1;
      lastWriteReg <= tg.accWrite;
      lastCsReg    <= tg.accCs;
      lastIdleReg  <= tg.accIdle;
    end
  end

  // saturating count of idle select cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      highRunReg <= '0;
    end else if (clkEnable) begin
      if (!tg.csHigh) begin
        highRunReg <= '0;
      end else if (highRunReg != '1) begin
        highRunReg <= highRunReg + 1'b1;
      end
    end
  end

endmodule

// [rtl/static_memory_bus_cycles.sv]
// static memory cycle sequencer: setup, split reads, stretched writes, turnaround
`timescale 1ns/10ps
module static_memory_bus_cycles #(
  parameter int NUM_SEL = static_mem_pkg::NUM_CS
) (
  // clock, reset and enable
  input  wire logic                                            clk,
  input  wire logic                                            reset,
  input  wire logic                                            clkEnable,
  // per-select timing
  input  wire logic [NUM_SEL-1:0][static_mem_pkg::WST_W-1:0]   waitStateCount,
  input  wire logic [NUM_SEL-1:0][static_mem_pkg::IDC_W-1:0]   idleCycleCount,
  // request
  input  wire logic                                            reqValid,
  output wire logic                                            reqReady,
  input  wire logic                                            reqWrite,
  input  wire logic                                            reqSdram,
  input  wire logic [static_mem_pkg::CS_W-1:0]                 reqCs,
  input  wire static_mem_pkg::bus_width_type                   reqWidth,
  input  wire logic [static_mem_pkg::ADDR_W-1:0]               reqAddr,
  input  wire logic [static_mem_pkg::DATA_W-1:0]               reqWData,
  input  wire logic [3:0]                                      reqByteEn,
  // answer
  output wire logic                                            rspValid,
  output wire logic [static_mem_pkg::DATA_W-1:0]               rspData,
  output wire logic                                            sdramGrant,
  // memory pins
  output wire logic [static_mem_pkg::ADDR_W-1:0]               locationLines,
  output wire logic [NUM_SEL-1:0]                              chipSelectN,
  output wire logic                                            readStrobeN,
  output wire logic                                            writeStrobeN,
  output wire logic [3:0]                                      byteLaneMaskN,
  input  wire logic [static_mem_pkg::DATA_W-1:0]               valueLinesIn,
  output wire logic [static_mem_pkg::DATA_W-1:0]               valueLinesOut,
  output wire logic [static_mem_pkg::DATA_W-1:0]               valueLinesOe,
  input  wire logic                                            holdOffRequestN
);
  import static_mem_pkg::*;

  seq_state_type      stateReg;
  seq_state_type      stateNext;
  logic [ADDR_W-1:0]  addrReg;
  logic [CS_W-1:0]    selReg;
  bus_width_type      widthReg;
  logic               writeReg;
  logic               sdramReg;
  logic [DATA_W-1:0]  wdataReg;
  logic [3:0]         beReg;
  logic [1:0]         beatReg;
  logic               holdOffSync1;
  logic               holdOffSync2;
  logic [DATA_W-1:0]  valueSync1;
  logic [DATA_W-1:0]  valueSync2;
  logic [1:0]         capPipeReg;
  logic [1:0]         capLastReg;
  logic [1:0]         capBeat1Reg;
  logic [1:0]         capBeat2Reg;
  bus_width_type      capWidthReg;
  logic               rspValidReg;
  logic [DATA_W-1:0]  rspDataReg;

  timing_if tif ();

  phase_timer u_timer (
    .clk       (clk),
    .reset     (reset),
    .clkEnable (clkEnable),
    .tt        (tif.timer)
  );

  turnaround_guard u_guard (
    .clk       (clk),
    .reset     (reset),
    .clkEnable (clkEnable),
    .tg        (tif.guard)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decoding

  wire logic              accept     = reqValid && reqReady && clkEnable;
  wire logic [2:0]        stepBytes  = byte_step(widthReg);
  wire logic [1:0]        lastIdx    = 2'(beat_count(widthReg) - 3'h1);
  wire logic              lastBeat   = (beatReg == lastIdx);
  wire logic [3:0]        laneMask   = lane_enable(widthReg);
  wire logic [WST_W-1:0]  curWst     = waitStateCount[selReg];
  wire logic [IDC_W-1:0]  curIdle    = idleCycleCount[selReg];
  wire logic              holdOffOn  = !holdOffSync2;
  wire logic              csLow      = stateReg inside {ST_READ, ST_WRITE, ST_WAITING, ST_WREND};
  wire logic              inSetup    = (stateReg == ST_SETUP);
  wire logic              readDone   = (stateReg == ST_READ) && tif.tmrDone;
  wire logic              writeNext  = (stateReg == ST_HOLD) && writeReg && !lastBeat;
  // next beat of a split access
  wire logic              advance    = (readDone && !lastBeat) || writeNext;
  wire logic              lastAfter  = inSetup ? lastBeat : (2'(beatReg + 2'h1) == lastIdx);
  wire logic [CNT_W-1:0]  wstWide    = CNT_W'(curWst);

  ////////////////////////////////////////////////////////////////////////////////
  // phase timer and turnaround guard hookup

  assign tif.tmrLoad  = (inSetup && tif.gapOk) || (readDone && !lastBeat);
  assign tif.tmrValue = CNT_W'(wstWide + ((!writeReg && lastAfter) ? LAST_PHASE_EXTRA :
                                                                    BEAT_PHASE_EXTRA));
  assign tif.accStart = inSetup && tif.gapOk;
  assign tif.accWrite = writeReg;
  assign tif.accCs    = selReg;
  assign tif.accIdle  = curIdle;
  assign tif.nxtWrite = writeReg;
  assign tif.nxtCs    = selReg;
  assign tif.nxtSync  = sdramReg;
  assign tif.csHigh   = !csLow;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  // next state
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_IDLE: begin
        if (accept) begin
          stateNext = reqSdram ? ST_SDGAP : ST_SETUP;
        end
      end
      // one setup cycle at least, longer while the gap runs
      ST_SETUP: begin
        if (tif.gapOk) begin
          stateNext = writeReg ? ST_WRITE : ST_READ;
        end
      end
      ST_READ: begin
        if (tif.tmrDone && lastBeat) begin
          stateNext = ST_HOLD;
        end
      end
      // hold-off only counts while the strobe is out
      ST_WRITE: begin
        if (holdOffOn) begin
          stateNext = ST_WAITING;
        end else if (tif.tmrDone) begin
          stateNext = ST_WREND;
        end
      end
      // no timeout: the device bounds the stretch
      ST_WAITING: begin
        if (!holdOffOn) begin
          stateNext = ST_WREND;
        end
      end
      // strobe up first, select one cycle later
      ST_WREND: stateNext = ST_HOLD;
      ST_HOLD: stateNext = writeNext ? ST_SETUP : ST_IDLE;
      // idle gap before the shared lines go to sdram
      ST_SDGAP: begin
        if (tif.gapOk) begin
          stateNext = ST_IDLE;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  // state and pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      stateReg     <= ST_IDLE;
      holdOffSync1 <= 1'b1;
      holdOffSync2 <= 1'b1;
      valueSync1   <= '0;
      valueSync2   <= '0;
    end else if (clkEnable) begin
      stateReg     <= stateNext;
      holdOffSync1 <= holdOffRequestN;
      holdOffSync2 <= holdOffSync1;
      valueSync1   <= valueLinesIn;
      valueSync2   <= valueSync1;
    end
  end

  // request capture and beat advance; an out-of-range select falls back to 0
  always_ff @(posedge clk) begin
    if (reset) begin
      addrReg  <= '0;
      selReg   <= '0;
      widthReg <= BUS_32;
      writeReg <= 1'b0;
      sdramReg <= 1'b0;
      wdataReg <= '0;
      beReg    <= 4'h0;
      beatReg  <= 2'h0;
    end else if (accept) begin
      addrReg  <= reqAddr;
      selReg   <= (32'(reqCs) < NUM_SEL) ? reqCs : '0;
      widthReg <= reqWidth;
      writeReg <= reqWrite;
      sdramReg <= reqSdram;
      wdataReg <= reqWData;
      beReg    <= reqByteEn;
      beatReg  <= 2'h0;
    end else if (clkEnable && advance) begin
      addrReg  <= ADDR_W'(addrReg + ADDR_W'(stepBytes));
      wdataReg <= wdataReg >> {stepBytes, 3'h0};
      beReg    <= beReg >> stepBytes;
      beatReg  <= 2'(beatReg + 2'h1);
    end
  end

  // read capture two cycles after the beat end, behind the pin synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      capPipeReg  <= 2'h0;
      capLastReg  <= 2'h0;
      capBeat1Reg <= 2'h0;
      capBeat2Reg <= 2'h0;
      capWidthReg <= BUS_32;
    end else if (clkEnable) begin
      capPipeReg  <= {capPipeReg[0], readDone};
      capLastReg  <= {capLastReg[0], readDone && lastBeat};
      capBeat1Reg <= beatReg;
      capBeat2Reg <= capBeat1Reg;
      capWidthReg <= widthReg;
    end
  end

  // answer word assembly, low beat in the low bits
  always_ff @(posedge clk) begin
    if (reset) begin
      rspDataReg  <= '0;
      rspValidReg <= 1'b0;
    end else if (clkEnable) begin
      rspValidReg <= (capPipeReg[1] && capLastReg[1]) ||
                     ((stateReg == ST_HOLD) && writeReg && lastBeat);
      if (capPipeReg[1]) begin
        unique case (capWidthReg)
          BUS_8:   rspDataReg[{capBeat2Reg, 3'h0} +: 8]  <= valueSync2[7:0];
          BUS_16:  rspDataReg[{capBeat2Reg[0], 4'h0} +: 16] <= valueSync2[15:0];
          default: rspDataReg <= valueSync2;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs; strobes decode one-hot state flops, the read strobe also gated by writeReg

  wire logic [3:0] oeLanes = (writeReg && (csLow || stateReg == ST_HOLD)) ? laneMask : 4'h0;

  assign reqReady      = (stateReg == ST_IDLE);
  assign rspValid      = rspValidReg;
  assign rspData       = rspDataReg;
  assign sdramGrant    = (stateReg == ST_SDGAP) && tif.gapOk;
  assign locationLines = addrReg;
  // read strobe tracks select over all beats
  assign readStrobeN   = !(csLow && !writeReg);
  assign writeStrobeN  = !(stateReg inside {ST_WRITE, ST_WAITING});
  assign byteLaneMaskN = csLow ? ~(writeReg ? (beReg & laneMask) : laneMask) : LANES_IDLE;
  assign valueLinesOut = wdataReg;
  assign valueLinesOe  = {{8{oeLanes[3]}}, {8{oeLanes[2]}}, {8{oeLanes[1]}}, {8{oeLanes[0]}}};

  // chip select decode
  genvar g;
  for (g = 0; g < NUM_SEL; g++) begin : g_sel
    assign chipSelectN[g] = !(csLow && (32'(selReg) == g));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks and the helper counters they read

  wire logic         csAllHigh = &chipSelectN;
  logic [ADDR_W-1:0] addrPrevA;
  logic [7:0]        phaseRunA;
  logic [7:0]        rdLowA;
  logic [7:0]        csHighRunA;
  logic              prevValidA;
  logic              prevWriteA;
  logic [CS_W-1:0]   prevSelA;
  logic [IDC_W-1:0]  prevIdleA;

  // phase, strobe and gap run lengths
  always_ff @(posedge clk) begin
    if (reset) begin
      addrPrevA  <= '0;
      phaseRunA  <= 8'h00;
      rdLowA     <= 8'h00;
      csHighRunA <= 8'h00;
      prevValidA <= 1'b0;
      prevWriteA <= 1'b0;
      prevSelA   <= '0;
      prevIdleA  <= '0;
    end else if (clkEnable) begin
      addrPrevA  <= locationLines;
      phaseRunA  <= csAllHigh ? 8'h00 : (locationLines != addrPrevA) ? 8'h01 :
                    8'(phaseRunA + 8'h01);
      rdLowA     <= readStrobeN ? 8'h00 : 8'(rdLowA + 8'h01);
      csHighRunA <= !csAllHigh ? 8'h00 : (csHighRunA == 8'hff) ? csHighRunA :
                    8'(csHighRunA + 8'h01);
      if ($fell(csAllHigh)) begin
        prevValidA <= 1'b1;
        prevWriteA <= writeReg;
        prevSelA   <= selReg;
        prevIdleA  <= curIdle;
      end
    end
  end

  property p_addr_setup;
    @(posedge clk) disable iff (reset) $fell(csAllHigh) |-> $stable(locationLines);
  endproperty
  a_addr_setup: assert property (p_addr_setup)
    else $error("address moved as select asserted");

  property p_addr_hold;
    @(posedge clk) disable iff (reset) $rose(csAllHigh) |-> $stable(locationLines);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved as select deasserted");

  property p_byte_beat;
    @(posedge clk) disable iff (reset)
      !csAllHigh && $past(!csAllHigh) && widthReg == BUS_8 && $changed(locationLines)
      |-> phaseRunA == 8'(wstWide + 8'h01);
  endproperty
  a_byte_beat: assert property (p_byte_beat)
    else $error("byte beat length wrong");

  property p_half_beat;
    @(posedge clk) disable iff (reset)
      !csAllHigh && !writeReg && widthReg == BUS_16 && $changed(locationLines)
      |-> phaseRunA == 8'(wstWide + 8'h01);
  endproperty
  a_half_beat: assert property (p_half_beat)
    else $error("first halfword phase length wrong");

  property p_last_phase;
    @(posedge clk) disable iff (reset)
      $rose(csAllHigh) && !writeReg && widthReg != BUS_32
      |-> phaseRunA == 8'(wstWide + 8'h02);
  endproperty
  a_last_phase: assert property (p_last_phase)
    else $error("final read phase length wrong");

  property p_rd_byte;
    @(posedge clk) disable iff (reset)
      $rose(readStrobeN) && widthReg == BUS_8 |-> rdLowA == 8'({wstWide, 2'h0} + 8'h05);
  endproperty
  a_rd_byte: assert property (p_rd_byte)
    else $error("byte-bus read strobe length wrong");

  property p_rd_half;
    @(posedge clk) disable iff (reset)
      $rose(readStrobeN) && widthReg == BUS_16 |-> rdLowA == 8'({wstWide, 1'b0} + 8'h03);
  endproperty
  a_rd_half: assert property (p_rd_half)
    else $error("halfword-bus read strobe length wrong");

  property p_wr_release;
    @(posedge clk) disable iff (reset)
      stateReg == ST_WAITING && !holdOffOn && clkEnable |=> $rose(writeStrobeN);
  endproperty
  a_wr_release: assert property (p_wr_release)
    else $error("write strobe late after hold-off release");

  property p_cs_release;
    @(posedge clk) disable iff (reset)
      stateReg == ST_WAITING && !holdOffOn && clkEnable
      |=> !csAllHigh ##1 (clkEnable ? csAllHigh : 1'b1);
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("select late after hold-off release");

  property p_gap_select;
    @(posedge clk) disable iff (reset)
      $fell(csAllHigh) && prevValidA && prevSelA != selReg
      |-> csHighRunA >= 8'(prevIdleA + 8'h01);
  endproperty
  a_gap_select: assert property (p_gap_select)
    else $error("idle gap short between selects");

  property p_gap_turn;
    @(posedge clk) disable iff (reset)
      $fell(csAllHigh) && prevValidA && prevWriteA != writeReg
      |-> csHighRunA >= 8'(prevIdleA + 8'h01);
  endproperty
  a_gap_turn: assert property (p_gap_turn)
    else $error("idle gap short on direction change");

  property p_gap_sdram;
    @(posedge clk) disable iff (reset)
      sdramGrant && prevValidA |-> csHighRunA >= 8'(prevIdleA);
  endproperty
  a_gap_sdram: assert property (p_gap_sdram)
    else $error("sdram granted before idle gap");

  property p_lanes;
    @(posedge clk) disable iff (reset)
      !csAllHigh && widthReg == BUS_8 |-> byteLaneMaskN[3:1] == 3'h7 && !valueLinesOe[8];
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte device lanes not masked");

endmodule

// [verification/async_mem_model.sv]
// behavioural asynchronous memory on the far side of the sequencer
`timescale 1ns/10ps
module async_mem_model (
  // clock
  input  wire logic        clk,
  // memory pins
  input  wire logic [5:0]  chipSelectN,
  input  wire logic        readStrobeN,
  input  wire logic        writeStrobeN,
  input  wire logic [25:0] locationLines,
  output wire logic [31:0] valueLinesIn,
  output wire logic        holdOffRequestN,
  // stretch length of a write, in clocks
  input  wire logic [9:0]  holdLen
);
  logic [9:0] cnt  = '0;
  logic       seen = 1'b0;
  logic       tgl  = 1'b0;
  wire  [7:0] l    = locationLines[7:0];
  wire        wrOn = ~&chipSelectN & ~writeStrobeN;
  //////////////////////////////////////////////////////////////////////////////
  // released lines toggle each clock so a stale sample cannot pass for data
  assign valueLinesIn = (&chipSelectN | readStrobeN) ? {32{tgl}} ^ 32'ha5a5a5a5
                      : {l + 8'h3, l + 8'h2, l + 8'h1, l} ^ 32'h5a5a5a5a;
  assign holdOffRequestN = (cnt == 10'h0);
  // one stretch per write window
  always @(posedge clk) begin
    tgl  <= ~tgl;
    seen <= wrOn;
    if (wrOn && !seen) cnt <= holdLen;
    else if (cnt != 10'h0) cnt <= cnt - 10'h1;
  end
endmodule

// [verification/static_memory_bus_cycles_test.sv]
// self-checking bench for the static memory cycle sequencer
`timescale 1ns/10ps
module static_memory_bus_cycles_test;
  import static_mem_pkg::*;
  logic          clk = 0, reset = 1, reqValid = 0, reqWrite = 0, reqSdram = 0;
  logic [4:0]    w = 5'h2;
  logic [2:0]    reqCs = 3'h0;
  bus_width_type reqWidth = BUS_32;
  logic [25:0]   reqAddr = '0, locationLines;
  logic [5:0]    chipSelectN;
  logic [31:0]   valueLinesIn, rspData, valueLinesOut, valueLinesOe, wrSeen = '0;
  logic [3:0]    byteLaneMaskN, maskSeen = 4'hf;
  logic          reqReady, rspValid, sdramGrant, readStrobeN, writeStrobeN, holdOffRequestN;
  logic [9:0]    holdLen = '0;
  logic          prevWr = 1, prevCs = 1;
  int            bad_count = 0, compares = 0, rdCnt = 0, relCnt = 0, gapCnt = 0;
  int            wrRel = 0, csRel = 0, lastGap = 0, rdLen = 0;
  //////////////////////////////////////////////////////////////////////////////
  // clock
  initial forever #5 clk = ~clk;
  static_memory_bus_cycles static_memory_bus_cycles_inst (
    .clk, .reset, .clkEnable(1'b1), .waitStateCount({6{w}}), .idleCycleCount({6{4'h5}}),
    .reqValid, .reqReady, .reqWrite, .reqSdram, .reqCs, .reqWidth, .reqAddr,
    .reqWData(32'hc3a51e07), .reqByteEn(4'hf), .rspValid, .rspData, .sdramGrant,
    .locationLines, .chipSelectN, .readStrobeN, .writeStrobeN, .byteLaneMaskN,
    .valueLinesIn, .valueLinesOut, .valueLinesOe, .holdOffRequestN);
  async_mem_model async_mem_model_inst (.clk, .chipSelectN, .readStrobeN, .writeStrobeN,
    .locationLines, .valueLinesIn, .holdOffRequestN, .holdLen);
  // pin timing counters, in whole clock periods
  always @(posedge clk) begin
    rdCnt  <= readStrobeN ? 0 : rdCnt + 1;
    relCnt <= holdOffRequestN ? relCnt + 1 : 0;
    gapCnt <= &chipSelectN ? gapCnt + 1 : 0;
    prevWr <= writeStrobeN;
    prevCs <= &chipSelectN;
    if (!prevWr && writeStrobeN) wrRel <= relCnt;
    if (!prevCs && &chipSelectN) csRel <= relCnt;
    if (prevCs && !(&chipSelectN)) lastGap <= gapCnt;
    // strobe window length is kept at its rise, so one process owns the run counter
    if (readStrobeN && rdCnt != 0) rdLen <= rdCnt;
    if (!(&chipSelectN)) maskSeen <= byteLaneMaskN;
    if (!prevWr && writeStrobeN) wrSeen <= valueLinesOut & valueLinesOe;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, got);
    compares++;
    if (exp !== got) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [31:0] pat(input logic [25:0] a);
    logic [7:0] l;
    l = a[7:0];
    pat = {l + 8'h3, l + 8'h2, l + 8'h1, l} ^ 32'h5a5a5a5a;
  endfunction
  // one request, held until taken, then a bounded wait for its answer
  task automatic access(input logic wr, sd, input logic [2:0] cs, input bus_width_type bw,
                        input logic [25:0] a);
    int n;
    @(negedge clk);
    {reqValid, reqWrite, reqSdram, reqCs, reqWidth, reqAddr} = {1'b1, wr, sd, cs, bw, a};
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    reqValid = 0;
    n = 0;
    while (rspValid !== 1'b1 && sdramGrant !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("answer", 1, n < 200);
  endtask
  task automatic test_read8;
    w = 5'h2;
    access(0, 0, 3'h0, BUS_8, 26'h100);
    chk("rd8 strobe", 4 * 2 + 5, rdLen);
    chk("rd8 data", pat(26'h100), rspData);
    chk("rd8 lanes", 4'he, maskSeen);
    $display("read8 done");
  endtask
  task automatic test_read16;
    w = 5'h3;
    access(0, 0, 3'h1, BUS_16, 26'h204);
    chk("rd16 strobe", 2 * 3 + 3, rdLen);
    chk("rd16 data", pat(26'h204), rspData);
    chk("rd16 lanes", 4'hc, maskSeen);
    chk("select gap", 1, lastGap >= 6);
    $display("read16 done");
  endtask
  task automatic test_write;
    w = 5'h8;
    holdLen = 10'd20;
    access(1, 0, 3'h1, BUS_32, 26'h300);
    chk("turn gap", 1, lastGap >= 6);
    chk("wr release", 1, wrRel inside {[2:4]});
    chk("cs release", 1, csRel inside {[3:5]});
    chk("wr lanes", 4'h0, maskSeen);
    chk("wr data", 32'hc3a51e07, wrSeen);
    holdLen = '0;
    $display("write done");
  endtask
  task automatic test_sdram;
    access(0, 1, 3'h0, BUS_32, 26'h0);
    chk("grant", 1, sdramGrant);
    // the grant cycle is itself the last idle cycle before the sdram select
    chk("sdram gap", 1, gapCnt + 1 >= 6);
    $display("sdram done");
  endtask
  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    reset = 0;
    test_read8();
    test_read16();
    test_write();
    test_sdram();
    final_report();
  end
  // watchdog: the four tests need a few hundred clocks at most
  initial begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule
